/* common/positive_input_pin_ctrl_pkg.sv */
// Package: register map, field positions, reset values and modes of the comparator control
package positive_input_pin_ctrl_pkg;
    // Register byte offsets
    localparam logic [7:0] status_control_offset = 8'h00;
    localparam logic [7:0] irq_status_offset     = 8'h04;
    localparam logic [7:0] irq_mask_offset       = 8'h08;
    // Field positions of comparator_status_control
    localparam int module_on_bit                 = 7;
    localparam int reference_select_internal_bit = 6;
    localparam int compare_event_flag_bit        = 5;
    localparam int compare_irq_enable_bit        = 4;
    localparam int comparator_level_bit          = 3;
    localparam int output_pin_enable_bit         = 2;
    localparam int event_edge_select_lsb         = 0;
    // Interrupt status/mask layout
    localparam int event_status_bit              = 0;
    // Reset values
    localparam logic [7:0] status_control_reset  = 8'h00;
    localparam logic [0:0] irq_status_reset      = 1'h0;
    localparam logic [0:0] irq_mask_reset        = 1'h0;
    // Edge modes
    localparam logic [1:0] edge_fall_a           = 2'h0;
    localparam logic [1:0] edge_rise             = 2'h1;
    localparam logic [1:0] edge_fall_b           = 2'h2;
    localparam logic [1:0] edge_both             = 2'h3;
    // AHB constants
    localparam logic [1:0] htrans_nonseq         = 2'h2;
    localparam logic [1:0] htrans_seq            = 2'h3;
    localparam logic [2:0] hsize_word            = 3'h2;
endpackage

/* hw/edge_sync.sv */
// Two-flop synchroniser of the comparator output with edge detection
`timescale 1ns/1ps
module edge_sync (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       clk_en,
    input  wire logic       clear,
    input  wire logic       async_in,
    output logic            level,
    output logic            rise,
    output logic            fall
);
    logic stage1;
    logic stage2;
    logic stage3;

    // Second flop alone reads the first; third holds the previous sample
    always_ff @(posedge hclk or negedge hresetn) begin // see [RL14]
        if (!hresetn) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
        end else if (clk_en) begin
            if (clear) begin
                stage1 <= 1'b0;
                stage2 <= 1'b0;
                stage3 <= 1'b0;
            end else begin
                stage1 <= async_in;
                stage2 <= stage1;
                stage3 <= stage2;
            end
        end
    end

    assign level = stage2;
    assign rise  = stage2 & ~stage3; // see [RL14]
    assign fall  = ~stage2 & stage3;
endmodule

/* hw/analog_comparator_control.sv */
// Control, status and interrupt logic around the analog comparator, AHB-Lite slave
// What this block does
// [RL1] module_on enables comparator; when clear, comparator sleeps and reports nothing.
// [RL2] reference_select_internal picks positive pin (0) or bandgap (1) as non-inverting input.
// [RL3] compare_event_flag sets on each compare event of the selected edge type.
// [RL4] Writing one clears compare_event_flag; writing zero leaves it alone.
// [RL5] Edge select: 00 and 10 falling, 01 rising, 11 both edges.
// [RL6] Interrupt request high while compare_irq_enable and compare_event_flag both set.
// [RL7] Interrupt drops once either enable or flag clears; no other acknowledge.
// [RL8] compare_irq_enable is a plain read-write bit; writing zero clears it.
// [RL9] comparator_level reads live comparator output, zero when module_on clear.
// [RL10] output_pin_enable drives comparator output onto comparator_out_pin; else not.
// [RL11] Comparator output high when non-inverting exceeds inverting input, else low.
// [RL12] In stop with comparator on, events set flag and wake if interrupt enabled.
// [RL13] After deepest stop wake, all register bits return to reset values.
// [RL14] Comparator output passes two sync flops; edges from successive samples.
`timescale 1ns/1ps
module analog_comparator_control
    import positive_input_pin_ctrl_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        clk_en,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        comparator_raw,
    input  wire logic        deep_stop_wake,
    output logic             comparator_power_on,
    output logic             reference_internal_sel,
    output logic             comparator_out_pin,
    output logic             comparator_out_pin_oe,
    output logic             compare_irq,
    output logic             irq,
    output logic             wake_request
);
    import positive_input_pin_ctrl_pkg::*;

    // ==========================================================
    // Register state
    logic       module_on;
    logic       reference_select_internal;
    logic       compare_event_flag;
    logic       compare_irq_enable;
    logic       output_pin_enable;
    logic [1:0] event_edge_select;
    logic       irq_status;
    logic       irq_mask;

    // ==========================================================
    // AHB-Lite address phase capture
    logic       wr_pending;
    logic       rd_pending;
    logic [7:0] addr_latched;
    logic       access_ok;

    function automatic logic is_word_access(input logic [1:0] tr, input logic [2:0] sz);
        is_word_access = (tr == htrans_nonseq || tr == htrans_seq) && sz == hsize_word;
    endfunction

    assign access_ok = hsel && hready && is_word_access(htrans, hsize);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pending   <= 1'b0;
            rd_pending   <= 1'b0;
            addr_latched <= 8'h00;
        end else if (clk_en) begin
            if (hready) begin
                wr_pending   <= access_ok && hwrite;
                rd_pending   <= access_ok && !hwrite;
                addr_latched <= haddr[7:0];
            end
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    logic wr_ctrl;
    logic wr_istat;
    logic wr_imask;
    assign wr_ctrl  = wr_pending && addr_latched == status_control_offset;
    assign wr_istat = wr_pending && addr_latched == irq_status_offset;
    assign wr_imask = wr_pending && addr_latched == irq_mask_offset;

    // ==========================================================
    // Comparator sampling and edge detection
    logic level;
    logic rise;
    logic fall;

    edge_sync u_sync (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .clk_en   (clk_en),
        .clear    (!module_on),
        .async_in (comparator_raw), // see [RL11]
        .level    (level),
        .rise     (rise),
        .fall     (fall)
    );

    logic compare_event;
    always_comb begin
        compare_event = 1'b0;
        unique case (event_edge_select) // see [RL5]
            edge_fall_a: compare_event = fall;
            edge_rise:   compare_event = rise;
            edge_fall_b: compare_event = fall;
            edge_both:   compare_event = rise | fall;
        endcase
        if (!module_on) begin
            compare_event = 1'b0; // see [RL1]
        end
    end

    // ==========================================================
    // Control bits, all returned to reset on deep stop wake
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            module_on                 <= status_control_reset[module_on_bit];
            reference_select_internal <= status_control_reset[reference_select_internal_bit];
            compare_irq_enable        <= status_control_reset[compare_irq_enable_bit];
            output_pin_enable         <= status_control_reset[output_pin_enable_bit];
            event_edge_select         <= status_control_reset[event_edge_select_lsb +: 2];
        end else if (clk_en) begin
            if (deep_stop_wake) begin // see [RL13]
                module_on                 <= status_control_reset[module_on_bit];
                reference_select_internal <= status_control_reset[reference_select_internal_bit];
                compare_irq_enable        <= status_control_reset[compare_irq_enable_bit];
                output_pin_enable         <= status_control_reset[output_pin_enable_bit];
                event_edge_select         <= status_control_reset[event_edge_select_lsb +: 2];
            end else if (wr_ctrl) begin
                module_on                 <= hwdata[module_on_bit]; // see [RL1]
                reference_select_internal <= hwdata[reference_select_internal_bit]; // see [RL2]
                compare_irq_enable        <= hwdata[compare_irq_enable_bit]; // see [RL8]
                output_pin_enable         <= hwdata[output_pin_enable_bit];
                event_edge_select         <= hwdata[event_edge_select_lsb +: 2];
            end
        end
    end

    // Event flag: set wins over a one-to-clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            compare_event_flag <= status_control_reset[compare_event_flag_bit];
        end else if (clk_en) begin
            if (deep_stop_wake) begin // see [RL13]
                compare_event_flag <= status_control_reset[compare_event_flag_bit];
            end else if (compare_event) begin
                compare_event_flag <= 1'b1; // see [RL3] [RL12]
            end else if (wr_ctrl && hwdata[compare_event_flag_bit]) begin
                compare_event_flag <= 1'b0; // see [RL4]
            end
        end
    end

    // Sticky interrupt status with mask
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status <= irq_status_reset;
            irq_mask   <= irq_mask_reset;
        end else if (clk_en) begin
            if (deep_stop_wake) begin
                irq_status <= irq_status_reset;
                irq_mask   <= irq_mask_reset;
            end else begin
                if (compare_event) begin
                    irq_status <= 1'b1;
                end else if (wr_istat && hwdata[event_status_bit]) begin
                    irq_status <= 1'b0;
                end
                if (wr_imask) begin
                    irq_mask <= hwdata[event_status_bit];
                end
            end
        end
    end

    // ==========================================================
    // Outputs
    logic comparator_level;
    assign comparator_level = module_on & level; // see [RL9]

    assign comparator_power_on    = module_on; // see [RL1]
    assign reference_internal_sel = reference_select_internal; // see [RL2]

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            comparator_out_pin    <= 1'b0;
            comparator_out_pin_oe <= 1'b0;
        end else if (clk_en) begin
            comparator_out_pin    <= output_pin_enable & comparator_level; // see [RL10]
            comparator_out_pin_oe <= output_pin_enable & module_on; // see [RL10]
        end
    end

    assign compare_irq  = compare_irq_enable & compare_event_flag; // see [RL6] [RL7]
    assign wake_request = compare_irq; // see [RL12]
    assign irq          = irq_status & irq_mask;

    // ==========================================================
    // Read data
    logic [7:0] ctrl_view;
    always_comb begin
        ctrl_view = 8'h00;
        ctrl_view[module_on_bit]                 = module_on;
        ctrl_view[reference_select_internal_bit] = reference_select_internal;
        ctrl_view[compare_event_flag_bit]        = compare_event_flag;
        ctrl_view[compare_irq_enable_bit]        = compare_irq_enable;
        ctrl_view[comparator_level_bit]          = comparator_level; // see [RL9]
        ctrl_view[output_pin_enable_bit]         = output_pin_enable;
        ctrl_view[event_edge_select_lsb +: 2]    = event_edge_select;
    end

    always_comb begin
        hrdata = 32'h0000_0000;
        if (rd_pending) begin
            unique case (addr_latched)
                status_control_offset: hrdata = {24'h000000, ctrl_view};
                irq_status_offset:     hrdata = {31'h0, irq_status};
                irq_mask_offset:       hrdata = {31'h0, irq_mask};
                default:               hrdata = 32'h0000_0000;
            endcase
        end
    end
endmodule

/* sim/positive_input_pin_ctrl_assertions.sv */
// Port checker of the comparator control block
`timescale 1ns/1ps
module positive_input_pin_ctrl_assertions
    import positive_input_pin_ctrl_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        clk_en,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        comparator_raw,
    input wire logic        deep_stop_wake,
    input wire logic        comparator_power_on,
    input wire logic        reference_internal_sel,
    input wire logic        comparator_out_pin,
    input wire logic        comparator_out_pin_oe,
    input wire logic        compare_irq,
    input wire logic        wake_request
);
    import positive_input_pin_ctrl_pkg::*;
    // ==========
    // Data phase of control word accesses
    logic hit;
    logic wr_q;
    logic rd_q;
    assign hit = hsel && hready && htrans[1] && hsize == hsize_word
                 && haddr[7:0] == status_control_offset;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {wr_q, rd_q} <= 2'h0;
        end else if (clk_en) begin
            {wr_q, rd_q} <= {hit && hwrite, hit && !hwrite};
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ==========
    // Properties
    pin_gated_a: assert property (comparator_out_pin |-> comparator_out_pin_oe
        || $past(comparator_out_pin_oe)) else $error("pin driven without enable");
    off_quiet_a: assert property (!comparator_power_on [*3] |-> !comparator_out_pin)
        else $error("pin active while module off");
    wake_follow_a: assert property (wake_request == compare_irq)
        else $error("wake differs from irq");
    sync_delay_a: assert property ($stable(comparator_raw) [*4]
        and comparator_out_pin_oe [*4] |-> comparator_out_pin == comparator_raw)
        else $error("pin not following comparator");
    irq_clear_a: assert property (wr_q && clk_en && !hwdata[4] |=> !compare_irq)
        else $error("irq stays after enable cleared");
    ctrl_write_a: assert property (wr_q && clk_en && !deep_stop_wake |=>
        comparator_power_on == $past(hwdata[7]) && reference_internal_sel == $past(hwdata[6]))
        else $error("control write not applied");
    read_fields_a: assert property (rd_q |-> hrdata[7] == comparator_power_on
        && hrdata[6] == reference_internal_sel && hrdata[31:8] == 24'h0)
        else $error("control read differs");
    read_level_a: assert property (rd_q && !comparator_power_on |-> !hrdata[3])
        else $error("level read while off");
    irq_flag_a: assert property (rd_q |-> compare_irq == (hrdata[5] && hrdata[4]))
        else $error("irq not flag and enable");
    deep_reset_a: assert property (deep_stop_wake && clk_en |=> !comparator_power_on
        && !compare_irq) else $error("deep wake left state");
    cover property (rd_q && hrdata[5]);
    cover property ($rose(compare_irq));
    cover property ($fell(comparator_raw) && comparator_out_pin_oe);
endmodule
bind analog_comparator_control positive_input_pin_ctrl_assertions positive_input_pin_ctrl_assertions_i (.*);

/* sim/comparator_core_model.sv */
// Behavioural analog comparator core with its input pins
`timescale 1ns/1ps
module comparator_core_model #(
    parameter logic [7:0] bandgap_level = 8'h80
) (
    input  wire logic       hclk,
    input  wire logic       power_on,
    input  wire logic       internal_ref,
    input  wire logic [7:0] positive_input_pin,
    input  wire logic [7:0] negative_input_pin,
    output logic            comparator_raw
);
    logic idle = 1'b0;
    // Powered-down core gives a changing pattern, not a held level
    always @(posedge hclk) idle <= !idle;
    always_comb begin
        if (!power_on) begin
            comparator_raw = idle;
        end else if (internal_ref) begin
            comparator_raw = bandgap_level > negative_input_pin;
        end else begin
            comparator_raw = positive_input_pin > negative_input_pin;
        end
    end
endmodule

/* sim/analog_comparator_control_tb.sv */
// Self-checking bench of the comparator control with a core model
`timescale 1ns/1ps
module analog_comparator_control_tb;
    import positive_input_pin_ctrl_pkg::*;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        deep = 1'b0;
    logic        cen = 1'b1;
    logic [7:0]  pos = 8'h10;
    logic [7:0]  neg = 8'h41;
    logic [31:0] hrdata, rd, s;
    logic        hrdy, hresp, raw, pwr, rsel, pin, oe, cirq, irq, e, wake;
    int          err_total = 0;
    int          checked = 0;
    int          cycles = 0;
    always #20 hclk = !hclk;
    analog_comparator_control analog_comparator_control_i (
        .hclk(hclk), .hresetn(hresetn), .clk_en(cen), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize_word), .hwdata(hwdata),
        .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp),
        .comparator_raw(raw), .deep_stop_wake(deep), .comparator_power_on(pwr),
        .reference_internal_sel(rsel), .comparator_out_pin(pin),
        .comparator_out_pin_oe(oe), .compare_irq(cirq), .irq(irq), .wake_request(wake));
    comparator_core_model comparator_core_model_i (
        .hclk(hclk), .power_on(pwr), .internal_ref(rsel), .positive_input_pin(pos),
        .negative_input_pin(neg), .comparator_raw(raw));
    // ==========
    // Tasks
    task automatic conclude();
        if (err_total == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= htrans_nonseq;
        do @(posedge hclk); while (hrdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hrdy !== 1'b1);
        rd = hrdata;
        chk("resp", 32'h0, {31'h0, hresp});
    endtask
    function automatic logic hit(input logic [1:0] m, input logic rising);
        return rising ? (m == edge_rise || m == edge_both) : (m != edge_rise);
    endfunction
    always @(posedge hclk) begin
        cycles++;
        if (cycles > 5000) begin
            err_total++;
            conclude();
        end
    end
    // ==========
    // Sequence
    initial begin
        s = $urandom(32'h9D2E);
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        xfer(1'b0, status_control_offset, 32'h0);
        chk("ctrl reset", 32'h0, rd);
        xfer(1'b1, irq_mask_offset, 32'h1);
        for (int m = 0; m < 4; m++) begin
            for (int r = 0; r < 2; r++) begin
                pos <= r ? 8'h10 : 8'h70;
                xfer(1'b1, status_control_offset, 32'hB4 | m);
                repeat (6) @(posedge hclk);
                xfer(1'b1, status_control_offset, 32'hB4 | m);
                xfer(1'b1, irq_status_offset, 32'h1);
                pos <= r ? 8'h70 : 8'h10;
                repeat (6) @(posedge hclk);
                e = hit(m[1:0], r[0]);
                xfer(1'b0, status_control_offset, 32'h0);
                chk("ctrl", {24'h0, 2'h2, e, 1'b1, r[0], 1'b1, m[1:0]}, rd);
                chk("irq", {29'h0, e, e, e}, {29'h0, cirq, irq, wake});
                chk("pin", {30'h0, r[0], 1'b1}, {30'h0, pin, oe});
                xfer(1'b1, status_control_offset, 32'h84 | m);
                xfer(1'b0, status_control_offset, 32'h0);
                chk("flag kept", {30'h0, e, 1'b0}, {30'h0, rd[5:4]});
                chk("irq off", 32'h0, {31'h0, cirq});
                xfer(1'b1, status_control_offset, 32'hA4 | m);
                xfer(1'b0, status_control_offset, 32'h0);
                chk("flag cleared", 32'h0, {31'h0, rd[5]});
            end
        end
        xfer(1'b1, irq_mask_offset, 32'h0);
        xfer(1'b0, irq_status_offset, 32'h0);
        chk("masked", 32'h2, {rd[30:0], irq});
        xfer(1'b1, irq_status_offset, 32'h1);
        xfer(1'b0, irq_status_offset, 32'h0);
        chk("status clear", 32'h0, rd);
        xfer(1'b1, status_control_offset, 32'h24);
        repeat (8) @(posedge hclk);
        xfer(1'b0, status_control_offset, 32'h0);
        chk("module off", 32'h4, {rd[31:1], pin});
        cen <= 1'b0;
        xfer(1'b1, status_control_offset, 32'h80);
        cen <= 1'b1;
        xfer(1'b0, status_control_offset, 32'h0);
        chk("frozen", 32'h4, rd);
        for (int i = 0; i < 12; i++) begin
            s = $urandom;
            pos <= {s[7:1], 1'b0};
            neg <= {s[15:9], 1'b1};
            xfer(1'b1, status_control_offset, {24'h0, 1'b1, s[16], 6'h0});
            repeat (5) @(posedge hclk);
            xfer(1'b0, status_control_offset, 32'h0);
            e = (s[16] ? 8'h80 : {s[7:1], 1'b0}) > {s[15:9], 1'b1};
            chk("level", {30'h0, s[16], e}, {30'h0, rsel, rd[3]});
        end
        xfer(1'b1, 8'h0C, 32'hFFFFFFFF);
        xfer(1'b0, 8'h0C, 32'h0);
        chk("unmapped", 32'h0, rd);
        deep <= 1'b1;
        @(posedge hclk);
        deep <= 1'b0;
        xfer(1'b0, status_control_offset, 32'h0);
        chk("deep wake", 32'h0, rd);
        conclude();
    end
endmodule
